// ---- rtl/cac_defs.svh ----
// Purpose: offsets, field positions and reset values of the capture/compare block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only, shared by the package and the design modules
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH

// register byte offsets
`define CAC_OFS_CTRL 8'h00
`define CAC_OFS_MODE 8'h04
`define CAC_OFS_CCL 8'h08
`define CAC_OFS_CCH 8'h0C
`define CAC_OFS_CNT 8'h10
`define CAC_OFS_STAT 8'h14

// counter_array_control bits
`define CAC_CTRL_FLAG 0
`define CAC_CTRL_RUN 6
`define CAC_CTRL_OVF 7

// module_mode_register bits
`define CAC_MODE_IRQ 0
`define CAC_MODE_PWM 1
`define CAC_MODE_TOG 2
`define CAC_MODE_MAT 3
`define CAC_MODE_FALL 4
`define CAC_MODE_RISE 5
`define CAC_MODE_CMP 6
`define CAC_MODE_WIDE 7

// status bits
`define CAC_STAT_PIN 0
`define CAC_STAT_OUT 1

// reset values and limits
`define CAC_MODE_RST 8'h00
`define CAC_BYTE_RST 8'h00
`define CAC_CNT_RST 16'h0000
`define CAC_CNT_MAX 16'hFFFF
`define CAC_LOW_MAX 8'hFF
`define CAC_WORD_ZERO 32'h00000000

`endif

// ---- rtl/cac_pkg.sv ----
// Purpose: types of the capture/compare block
// Assumes: cac_defs.svh holds all numeric constants
// Notes: every module keeps its state in one of these structs
`include "cac_defs.svh"

package cac_pkg;

   typedef enum logic [2:0] {MODE_IDLE, MODE_CAPTURE, MODE_TIMER, MODE_HSO, MODE_FREQ, MODE_PWM8,
      MODE_PWM16} cac_mode_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0] ccl;
      logic [7:0] cch;
      logic [7:0] mode;
      logic run;
      logic flag;
      logic ovf;
      logic out;
      logic oe;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cac_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic rise;
      logic fall;
   } cac_sync_t;

   typedef struct packed {
      logic eq_prev;
      logic match;
   } cac_cmp_t;

endpackage

// ---- rtl/cac_pin_sync.sv ----
// Purpose: brings the capture pin into the core clock domain and finds its edges
// Assumes: pin level is held at least two core clocks
// Notes: rise and fall are one-cycle pulses from flip-flops
`timescale 1ns/1ps

module cac_pin_sync
   import cac_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // asynchronous pin
   input wire logic pin_in,
   // synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);

   cac_sync_t r_reg;
   cac_sync_t r_next;

   // first stage feeds only the second stage
   always_comb
   begin
      r_next = r_reg;
      r_next.s1 = pin_in;
      r_next.s2 = r_reg.s1;
      r_next.prev = r_reg.s2;
      r_next.rise = r_reg.s2 & ~r_reg.prev;
      r_next.fall = ~r_reg.s2 & r_reg.prev;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign level = r_reg.s2;
   assign rise = r_reg.rise;
   assign fall = r_reg.fall;

endmodule

// ---- rtl/cac_comparator.sv ----
// Purpose: digital comparator between counter and capture/compare value
// Assumes: same clock as the counter
// Notes: match is a registered one-cycle pulse in the cycle after the first cycle of equality
`timescale 1ns/1ps

module cac_comparator
   import cac_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // operands
   input wire logic enable,
   input wire logic low_only,
   input wire logic [15:0] count,
   input wire logic [15:0] value,
   // result
   output logic match
);

   cac_cmp_t r_reg;
   cac_cmp_t r_next;
   logic eq;

   // a stopped counter sitting on the value gives one pulse, not a stream
   always_comb
   begin
      r_next = r_reg;
      if (low_only)
         eq = enable && (count[7:0] == value[7:0]);
      else
         eq = enable && (count == value);
      r_next.eq_prev = eq;
      r_next.match = eq & ~r_reg.eq_prev;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign match = r_reg.match;

endmodule

// ---- rtl/cac_capture_compare.sv ----
// Purpose: one capture/compare module of a 16-bit counter array, with its counter and APB registers
// Assumes: APB master per the protocol; capture pin asynchronous to core_clk
// Notes: output and PWM waveforms kept simple; counter clock is core_clk
//
// Overview of operation
// R1: enabled flag raises the shared interrupt
// R2: comparator off stops output pin toggling
// R3: comparator off forces PWM output low
// R4: match sets flag when match enabled
// R5: capture edge copies counter into register
// R6: select bits choose rising, falling, both
// R7: every capture sets the event flag
// R8: capture interrupts only when enabled
// R9: flag cleared only by software write
// R10: pin level readable in status register
// R11: source holds pin two clocks minimum
// R12: low write clears, high sets comparator
// R13: mode irq bit enables flag interrupt
// R14: pin synchronised; load and flag together
`timescale 1ns/1ps

`include "cac_defs.svh"

module cac_capture_compare
   import cac_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // capture/output pin
   input wire logic module_capture_pin_in,
   output logic module_capture_pin_out,
   output logic module_capture_pin_oe,
   // shared counter-array interrupt
   output logic counter_array_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   cac_state_t r_reg;
   cac_state_t r_next;

   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic cmp_match;
   logic cmp_low_only;
   logic cmp_enable;
   cac_mode_t mode_now;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode

   function automatic cac_mode_t decode_mode(input logic [7:0] m);
      cac_mode_t d;
      d = MODE_IDLE;
      // capture selects win, so a stray pwm bit never drives the pin while capturing
      if (m[`CAC_MODE_RISE] || m[`CAC_MODE_FALL])
         d = MODE_CAPTURE;
      else if (m[`CAC_MODE_PWM] && m[`CAC_MODE_WIDE])
         d = MODE_PWM16;
      else if (m[`CAC_MODE_PWM] && m[`CAC_MODE_TOG])
         d = MODE_FREQ;
      else if (m[`CAC_MODE_PWM])
         d = MODE_PWM8;
      else if (m[`CAC_MODE_TOG])
         d = MODE_HSO;
      else if (m[`CAC_MODE_CMP] || m[`CAC_MODE_MAT])
         d = MODE_TIMER;
      return d;
   endfunction

   assign mode_now = decode_mode(r_reg.mode);

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   function automatic logic [31:0] read_word(input cac_state_t s, input logic [7:0] a, input logic lvl);
      logic [31:0] w;
      // unmapped offsets read as zero so an error answer carries no state
      w = `CAC_WORD_ZERO;
      case (a)
         `CAC_OFS_CTRL:
         begin
            w[`CAC_CTRL_FLAG] = s.flag;
            w[`CAC_CTRL_RUN] = s.run;
            w[`CAC_CTRL_OVF] = s.ovf;
         end
         `CAC_OFS_MODE:
            w[7:0] = s.mode;
         `CAC_OFS_CCL:
            w[7:0] = s.ccl;
         `CAC_OFS_CCH:
            w[7:0] = s.cch;
         `CAC_OFS_CNT:
            w[15:0] = s.cnt;
         `CAC_OFS_STAT:
         begin
            // R10: pin level visible
            w[`CAC_STAT_PIN] = lvl;
            w[`CAC_STAT_OUT] = s.out;
         end
         default:
            w = `CAC_WORD_ZERO;
      endcase
      return w;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         `CAC_OFS_CTRL, `CAC_OFS_MODE, `CAC_OFS_CCL, `CAC_OFS_CCH, `CAC_OFS_CNT, `CAC_OFS_STAT:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and comparator

   // R14: two-flop pin sync
   cac_pin_sync u_pin_sync
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_in(module_capture_pin_in),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // 8-bit compare for the modes that work on the low byte only
   assign cmp_low_only = (mode_now == MODE_PWM8) || (mode_now == MODE_FREQ);
   // R2: comparator gated by enable bit
   assign cmp_enable = r_reg.mode[`CAC_MODE_CMP] && (mode_now != MODE_CAPTURE);

   // compare value is the two byte registers side by side
   cac_comparator u_comparator
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .enable(cmp_enable),
      .low_only(cmp_low_only),
      .count(r_reg.cnt),
      .value({r_reg.cch, r_reg.ccl}),
      .match(cmp_match)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic access;
      logic wr_take;
      logic cap_edge;
      logic low_wrap;
      logic full_wrap;
      access = 1'b0;
      wr_take = 1'b0;
      cap_edge = 1'b0;
      low_wrap = 1'b0;
      full_wrap = 1'b0;
      r_next = r_reg;

      // apb: first access cycle prepares the answer, the next edge completes it
      access = psel && penable;
      // a write lands on the edge that samples pready high, never earlier
      wr_take = access && pwrite && r_reg.pready;
      if (access && !r_reg.pready)
      begin
         r_next.pready = 1'b1;
         r_next.pslverr = !addr_mapped(paddr);
         r_next.prdata = pwrite ? `CAC_WORD_ZERO : read_word(r_reg, paddr, pin_level);
      end
      else
      begin
         r_next.pready = 1'b0;
         r_next.pslverr = 1'b0;
      end

      // counter runs on core_clk while enabled
      if (r_reg.run)
      begin
         r_next.cnt = 16'(r_reg.cnt + 16'h0001);
         low_wrap = (r_reg.cnt[7:0] == `CAC_LOW_MAX);
         full_wrap = (r_reg.cnt == `CAC_CNT_MAX);
      end

      // software writes first, so hardware events below win over a clear
      if (wr_take)
      begin
         case (paddr)
            `CAC_OFS_CTRL:
            begin
               // R9: only software clears the flag
               r_next.flag = r_reg.flag & pwdata[`CAC_CTRL_FLAG];
               r_next.ovf = r_reg.ovf & pwdata[`CAC_CTRL_OVF];
               r_next.run = pwdata[`CAC_CTRL_RUN];
            end
            `CAC_OFS_MODE:
               r_next.mode = pwdata[7:0];
            `CAC_OFS_CCL:
            begin
               r_next.ccl = pwdata[7:0];
               // R12: low write disables comparator
               r_next.mode[`CAC_MODE_CMP] = 1'b0;
            end
            `CAC_OFS_CCH:
            begin
               r_next.cch = pwdata[7:0];
               // R12: high write enables comparator
               r_next.mode[`CAC_MODE_CMP] = 1'b1;
            end
            `CAC_OFS_CNT:
               r_next.cnt = pwdata[15:0];
            default:
               r_next.run = r_next.run;
         endcase
      end

      if (full_wrap)
         r_next.ovf = 1'b1;

      // R6: edge select
      cap_edge = (pin_rise && r_reg.mode[`CAC_MODE_RISE]) || (pin_fall && r_reg.mode[`CAC_MODE_FALL]);

      // the pin is driven only in output and pwm modes; capture keeps it an input
      r_next.oe = 1'b0;
      case (mode_now)
         MODE_CAPTURE:
         begin
            // R11: edges shorter than two clocks may be missed
            if (cap_edge)
            begin
               // R5: counter into both bytes
               r_next.ccl = r_reg.cnt[7:0];
               r_next.cch = r_reg.cnt[15:8];
               // R7: capture sets flag
               r_next.flag = 1'b1;
            end
         end
         MODE_HSO:
         begin
            r_next.oe = 1'b1;
            // R2: no toggle while comparator off
            if (cmp_match && r_reg.mode[`CAC_MODE_CMP])
               r_next.out = ~r_reg.out;
         end
         MODE_FREQ:
         begin
            r_next.oe = 1'b1;
            // R2: frequency toggle needs comparator
            if (cmp_match && r_reg.mode[`CAC_MODE_CMP])
            begin
               r_next.out = ~r_reg.out;
               // the high byte is the half period, added at every toggle
               r_next.ccl = 8'(r_reg.ccl + r_reg.cch);
            end
         end
         MODE_PWM8:
         begin
            r_next.oe = 1'b1;
            // low byte wrap ends the period and reloads the duty value
            if (low_wrap)
            begin
               r_next.out = 1'b0;
               r_next.ccl = r_reg.cch;
            end
            else if (cmp_match)
               r_next.out = 1'b1;
            // R3: zero duty when comparator off
            if (!r_reg.mode[`CAC_MODE_CMP])
               r_next.out = 1'b0;
         end
         MODE_PWM16:
         begin
            r_next.oe = 1'b1;
            // a full wrap ends the high time
            if (full_wrap)
               r_next.out = 1'b0;
            else if (cmp_match)
               r_next.out = 1'b1;
            // R3: zero duty when comparator off
            if (!r_reg.mode[`CAC_MODE_CMP])
               r_next.out = 1'b0;
         end
         default:
            r_next.oe = 1'b0;
      endcase

      // R4: match sets flag
      if (cmp_match && r_reg.mode[`CAC_MODE_MAT] && r_reg.mode[`CAC_MODE_CMP])
         r_next.flag = 1'b1;

      // R1: flag drives shared interrupt
      // R8: interrupt only when enabled
      // R13: mode bit enables interrupt
      r_next.irq = r_next.flag && r_next.mode[`CAC_MODE_IRQ];
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   // reset values are constants only; flag and pin output start low
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r_reg <= '0;
         r_reg.mode <= `CAC_MODE_RST;
         r_reg.cnt <= `CAC_CNT_RST;
         r_reg.ccl <= `CAC_BYTE_RST;
         r_reg.cch <= `CAC_BYTE_RST;
         r_reg.prdata <= `CAC_WORD_ZERO;
      end
      else
         r_reg <= r_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops

   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign module_capture_pin_out = r_reg.out;
   assign module_capture_pin_oe = r_reg.oe;
   assign counter_array_irq = r_reg.irq;

endmodule

// ---- verification/cac_pin_src.sv ----
// Purpose: far-side source of the capture pin
// Assumes: bench asks for a level through lvl_req
// Notes: a level is never shortened below HOLD clocks
`timescale 1ns/1ps

module cac_pin_src #(parameter int HOLD = 2)
(
   // clock
   input wire logic core_clk,
   // level request and pin
   input wire logic lvl_req,
   output logic pin
);
   int age = 0;
   initial pin = 1'b0;
   always @(posedge core_clk)
   begin
      age <= age + 1;
      if (age >= HOLD - 1 && lvl_req != pin)
      begin
         pin <= lvl_req;
         age <= 0;
      end
   end
endmodule

// ---- verification/cac_capture_compare_asserts.sv ----
// Purpose: port-level checks of the capture/compare block
// Assumes: apb slave with one wait state
// Notes: age counts clocks since the pin last changed
`timescale 1ns/1ps
`include "cac_defs.svh"

module cac_capture_compare_asserts
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pin and interrupt
   input wire logic module_capture_pin_in,
   input wire logic module_capture_pin_out,
   input wire logic module_capture_pin_oe,
   input wire logic counter_array_irq
);
   logic pin_d;
   logic [3:0] age;
   // shadow of the match-flag enable, since a match may also raise the interrupt
   logic mat_sh;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_d <= 1'b0;
         age <= 4'h0;
         mat_sh <= 1'b0;
      end
      else
      begin
         if (psel && penable && pwrite && pready && paddr == `CAC_OFS_MODE)
            mat_sh <= pwdata[`CAC_MODE_MAT];
         pin_d <= module_capture_pin_in;
         if (module_capture_pin_in != pin_d)
            age <= 4'h0;
         else if (age != 4'hF)
            age <= age + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ready_after_access:
      assert property (psel && penable && !pready |=> pready) else $error("no answer to access");
   a_ready_one:
      assert property (pready |=> !pready) else $error("pready held too long");
   a_err_with_ready:
      assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_err_data_zero:
      assert property (pslverr |-> prdata == 32'h00000000) else $error("error read not zero");
   a_reset_quiet:
      assert property ($rose(resetn) |-> !counter_array_irq && !pready && !module_capture_pin_oe)
         else $error("outputs active after reset");
   a_irq_holds:
      assert property (counter_array_irq && !(psel && pwrite) |=> counter_array_irq)
         else $error("interrupt dropped without write");
   a_irq_cause:
      assert property ($rose(counter_array_irq) && !mat_sh |-> (age >= 4'h2 && age <= 4'h5)
         || $past(psel && penable && pwrite && pready) || $past(psel && penable && pwrite && pready, 2))
         else $error("interrupt without cause");
   a_stat_pin_level:
      assert property (pready && !pwrite && !pslverr && paddr == `CAC_OFS_STAT && age >= 4'h6
         |-> prdata[0] == module_capture_pin_in) else $error("status pin level wrong");
endmodule

bind cac_capture_compare cac_capture_compare_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .module_capture_pin_in(module_capture_pin_in),
   .module_capture_pin_out(module_capture_pin_out), .module_capture_pin_oe(module_capture_pin_oe),
   .counter_array_irq(counter_array_irq));

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the capture/compare block
// Assumes: apb answers after a wait state; counter stopped while capturing
// Notes: a stopped counter makes every captured value exact
`timescale 1ns/1ps
`include "cac_defs.svh"

module testbench;
   logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 0;
   logic [7:0] paddr = 8'h00, sel;
   logic [31:0] pwdata = 32'h00000000, q;
   logic [31:0] prdata;
   logic pready, pslverr, pin, pin_out, pin_oe, irq, e, ie, lv, qual, o;
   logic [15:0] val, exp_cc;
   logic [7:0] om [4] = '{8'h02, 8'h82, 8'h04, 8'h06};
   int error_cnt = 0, compares = 0, cyc = 0, bad;

   cac_pin_src SRC (.core_clk(core_clk), .lvl_req(lvl), .pin(pin));
   cac_capture_compare DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .module_capture_pin_in(pin), .module_capture_pin_out(pin_out),
      .module_capture_pin_oe(pin_oe), .counter_array_irq(irq));

   initial forever #4 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // wait for the rising edge at which pready is sampled high; the bench timeout ends a hang
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(exp, q & m);
   endtask

   task stop_test;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         rdc(8'(4 * i), 32'h000000FF, 32'h00000000);
      rdc(8'h18, 32'hFFFFFFFF, 32'h00000000);
      chk(32'h00000001, {31'h0, e});
      $display("test reset and unmapped done");
      apb(1'b1, `CAC_OFS_CCH, 32'h00000012);
      rdc(`CAC_OFS_MODE, 32'h00000040, 32'h00000040);
      apb(1'b1, `CAC_OFS_CCL, 32'h00000034);
      rdc(`CAC_OFS_MODE, 32'h00000040, 32'h00000000);
      exp_cc = 16'h1234;
      $display("test byte writes done");
      for (int m = 0; m < 3; m++)
      begin
         sel = (m == 0) ? 8'h20 : (m == 1) ? 8'h10 : 8'h30;
         ie = (m != 2);
         apb(1'b1, `CAC_OFS_MODE, {24'h0, sel | {7'h0, ie}});
         for (int k = 0; k < 2; k++)
         begin
            lv = (k == 0);
            val = 16'(16'h1111 * (2 * m + k + 1));
            apb(1'b1, `CAC_OFS_CNT, {16'h0, val});
            apb(1'b1, `CAC_OFS_CTRL, 32'h00000000);
            @(posedge core_clk);
            lvl <= lv;
            repeat (12) @(negedge core_clk);
            qual = lv ? sel[5] : sel[4];
            if (qual)
               exp_cc = val;
            chk({31'h0, qual & ie}, {31'h0, irq});
            rdc(`CAC_OFS_CTRL, 32'h00000001, {31'h0, qual});
            rdc(`CAC_OFS_CCL, 32'h000000FF, {24'h0, exp_cc[7:0]});
            rdc(`CAC_OFS_CCH, 32'h000000FF, {24'h0, exp_cc[15:8]});
            rdc(`CAC_OFS_STAT, 32'h00000001, {31'h0, lv});
            chk(32'h00000000, {31'h0, pin_oe});
         end
      end
      $display("test capture done");
      apb(1'b1, `CAC_OFS_MODE, 32'h00000031);
      repeat (2) @(negedge core_clk);
      chk(32'h00000001, {31'h0, irq});
      apb(1'b1, `CAC_OFS_CTRL, 32'h00000001);
      repeat (2) @(negedge core_clk);
      chk(32'h00000001, {31'h0, irq});
      apb(1'b1, `CAC_OFS_CTRL, 32'h00000000);
      repeat (2) @(negedge core_clk);
      chk(32'h00000000, {31'h0, irq});
      $display("test interrupt enable done");
      for (int t = 0; t < 2; t++)
      begin
         apb(1'b1, `CAC_OFS_MODE, 32'h00000008);
         apb(1'b1, `CAC_OFS_CCL, 32'h00000005);
         if (t == 0)
            apb(1'b1, `CAC_OFS_CCH, 32'h00000000);
         apb(1'b1, `CAC_OFS_CNT, 32'h00000000);
         apb(1'b1, `CAC_OFS_CTRL, 32'h00000040);
         repeat (20) @(posedge core_clk);
         rdc(`CAC_OFS_CTRL, 32'h00000001, {31'h0, t == 0});
         apb(1'b1, `CAC_OFS_CTRL, 32'h00000000);
      end
      $display("test compare done");
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, `CAC_OFS_MODE, {24'h0, om[i]});
         apb(1'b1, `CAC_OFS_CCL, 32'h00000010);
         apb(1'b1, `CAC_OFS_CNT, 32'h00000000);
         apb(1'b1, `CAC_OFS_CTRL, 32'h00000040);
         @(negedge core_clk);
         o = pin_out;
         chk(32'h00000001, {31'h0, pin_oe});
         bad = 0;
         repeat (300)
         begin
            @(negedge core_clk);
            if (pin_out !== o)
               bad++;
         end
         chk(32'h00000000, 32'(bad));
         if (om[i][1])
            chk(32'h00000000, {31'h0, o});
         apb(1'b1, `CAC_OFS_CTRL, 32'h00000000);
      end
      $display("test output modes done");
      stop_test();
   end
endmodule
